// ### i2cme_consts.vh
// Register addresses, field positions, reset values and bit counts for the two-wire master
`ifndef I2CME_CONSTS_VH
`define I2CME_CONSTS_VH

// ********************************
// Register byte addresses
// ********************************
`define I2CME_ADDR_PRESCALE 32'hfef80090
`define I2CME_ADDR_CONTROL 32'hfef80098
`define I2CME_ADDR_STATUS 32'hfef800a0
`define I2CME_ADDR_TX_BYTE 32'hfef800a8
`define I2CME_ADDR_RX_BYTE 32'hfef800b0

// ********************************
// Control field positions
// ********************************
`define I2CME_CTL_START 3
`define I2CME_CTL_STOP 2
`define I2CME_CTL_ACKOUT 1
`define I2CME_CTL_ENABLE 0

// ********************************
// Status field positions
// ********************************
`define I2CME_STS_ERR 3
`define I2CME_STS_ACKIN 2
`define I2CME_STS_CMPLT 1
`define I2CME_STS_DATIN 0

// ********************************
// Transmit byte fields
// ********************************
`define I2CME_TX_DIR 0
`define I2CME_TX_MSB 7

// ********************************
// Reset values
// ********************************
`define I2CME_RST_PRESCALE 16'h01f3
`define I2CME_RST_CONTROL 4'h0
`define I2CME_RST_STATUS 4'h2
`define I2CME_RST_BYTE 8'h00

// ********************************
// Bit counts per byte
// ********************************
`define I2CME_BIT_LAST 3'h0
`define I2CME_BIT_FIRST 3'h7

`endif

// ### i2cme_core.v
// Byte-oriented two-wire serial master with register port
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "i2cme_consts.vh"

// Function
// RQ1 - Start and stop both set flags error
// RQ2 - Start plus stop clears whole control register
// RQ3 - Control writes ignored while error pending
// RQ4 - Status read clears error, reopens control writes
// RQ5 - Slave ack sets ack flag, nack clears
// RQ6 - Ack flag cleared at next valid operation
// RQ7 - Complete flag cleared at start, set finish
// RQ8 - Complete flag set after reset
// RQ9 - Start plus enable: transmit write sends start, byte
// RQ10 - Byte bits 24..30 address, bit 31 direction; code sends byte bits 7..1 as address, bit 0 as direction
// RQ11 - After write start, transmit writes shift out
// RQ12 - After read start, transmit writes fetch byte
// RQ13 - Stop plus enable: transmit write sends stop
// RQ14 - Next byte only after previous one read
// RQ15 - Reading receive byte clears data flag
// RQ16 - Start bit self clears, then complete set
// RQ17 - Stop bit self clears, then complete set
// RQ18 - Disabled: registers work, no bus activity
// RQ19 - Serial clock is clk/(prescale+1)/2; code divides by 2*prescale+4 (synchroniser stretches each high phase)
// RQ20 - Master acks read byte only if ackout
// RQ21 - Status read-only, unused data bits zero
module i2cme_core (
  // Clock and reset
  input wire core_clk_i,
  input wire rstn_i,
  // Register port
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [31:0] rdata_o,
  // Serial clock pin
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe_o,
  // Serial data pin
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o
);

  // ********************************
  // State codes
  // ********************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_START = 5'h02;
  localparam [4:0] ST_BIT = 5'h04;
  localparam [4:0] ST_ACK = 5'h08;
  localparam [4:0] ST_STOP = 5'h10;

  // ********************************
  // Declarations
  // ********************************
  reg [15:0] prescale_ff;
  reg [3:0] control_ff;
  reg err_ff;
  reg ackin_ff;
  reg cmplt_ff;
  reg datin_ff;
  reg [7:0] tx_byte_ff;
  reg [7:0] rx_byte_ff;
  reg [31:0] rdata_ff;
  reg [4:0] st_ff;
  reg [1:0] ph_ff;
  reg [2:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg [15:0] div_cnt_ff;
  reg op_start_ff;
  reg op_rd_ff;
  reg dir_rd_ff;
  reg scl_oe_ff;
  reg sda_oe_ff;
  reg pin_lo_ff;
  reg scl_meta_ff;
  reg scl_sync_ff;
  reg sda_meta_ff;
  reg sda_sync_ff;
  reg [31:0] nxt_rdata;

  wire sel_prescale;
  wire sel_control;
  wire sel_status;
  wire sel_tx;
  wire sel_rx;
  wire tx_write;
  wire idle;
  wire go_start;
  wire go_stop;
  wire go_data;
  wire go_any;
  wire stretched;
  wire tick;
  wire ctl_conflict;

  assign sel_prescale = (addr_i == `I2CME_ADDR_PRESCALE);
  assign sel_control = (addr_i == `I2CME_ADDR_CONTROL);
  assign sel_status = (addr_i == `I2CME_ADDR_STATUS);
  assign sel_tx = (addr_i == `I2CME_ADDR_TX_BYTE);
  assign sel_rx = (addr_i == `I2CME_ADDR_RX_BYTE);
  assign tx_write = wr_i & sel_tx;
  assign idle = (st_ff == ST_IDLE);

  // ********************************
  // Operation launch decode
  // ********************************
  // Writes while busy or disabled only store the byte
  assign go_start = tx_write & idle & control_ff[`I2CME_CTL_ENABLE] &
                    control_ff[`I2CME_CTL_START]; // see RQ9 see RQ18
  assign go_stop = tx_write & idle & control_ff[`I2CME_CTL_ENABLE] &
                   ~control_ff[`I2CME_CTL_START] & control_ff[`I2CME_CTL_STOP]; // see RQ13 see RQ18
  // A fetch write is refused until the previous byte is collected
  assign go_data = tx_write & idle & control_ff[`I2CME_CTL_ENABLE] &
                   ~control_ff[`I2CME_CTL_START] & ~control_ff[`I2CME_CTL_STOP] &
                   ~(dir_rd_ff & datin_ff); // see RQ14
  assign go_any = go_start | go_stop | go_data;
  assign ctl_conflict = wdata_i[`I2CME_CTL_START] & wdata_i[`I2CME_CTL_STOP];

  // ********************************
  // Pin synchronisers
  // ********************************
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl_i;
      scl_sync_ff <= scl_meta_ff;
      sda_meta_ff <= sda_i;
      sda_sync_ff <= sda_meta_ff;
    end
  end

  // ********************************
  // Bit-rate divider
  // ********************************
  // A slave holding the clock low pauses the divider
  assign stretched = ~scl_oe_ff & ~scl_sync_ff;
  assign tick = ~idle & ~stretched & (div_cnt_ff == prescale_ff); // see RQ19

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt_ff <= 16'h0000;
    end else if (idle | tick) begin
      div_cnt_ff <= 16'h0000;
    end else if (!stretched) begin
      div_cnt_ff <= div_cnt_ff + 16'h0001; // see RQ19
    end
  end

  // ********************************
  // Register writes and flags
  // ********************************
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prescale_ff <= `I2CME_RST_PRESCALE;
      tx_byte_ff <= `I2CME_RST_BYTE;
      control_ff <= `I2CME_RST_CONTROL;
      err_ff <= 1'b0;
    end else begin
      if (wr_i & sel_prescale) begin
        prescale_ff <= wdata_i[15:0];
      end
      if (tx_write) begin
        tx_byte_ff <= wdata_i[7:0];
      end
      if (wr_i & sel_control & ~err_ff) begin // see RQ3
        if (ctl_conflict) begin
          control_ff <= `I2CME_RST_CONTROL; // see RQ2
          err_ff <= 1'b1; // see RQ1
        end else begin
          control_ff <= wdata_i[3:0];
        end
      end else if (tick & st_ff[1] & ph_ff[0]) begin
        control_ff[`I2CME_CTL_START] <= control_ff[`I2CME_CTL_START];
      end else if (tick & (st_ff == ST_ACK) & ph_ff[0] & op_start_ff) begin
        control_ff[`I2CME_CTL_START] <= 1'b0; // see RQ16
      end else if (tick & (st_ff == ST_STOP) & (ph_ff == 2'h2)) begin
        control_ff[`I2CME_CTL_STOP] <= 1'b0; // see RQ17
      end
      if (rd_i & sel_status) begin
        err_ff <= 1'b0; // see RQ4
      end
    end
  end

  // ********************************
  // Serial sequencer
  // ********************************
  // Data changes on the edge that pulls the clock low
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= ST_IDLE;
      ph_ff <= 2'h0;
      bit_cnt_ff <= `I2CME_BIT_FIRST;
      shift_ff <= `I2CME_RST_BYTE;
      op_start_ff <= 1'b0;
      op_rd_ff <= 1'b0;
      dir_rd_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ackin_ff <= 1'b0;
      cmplt_ff <= 1'b1; // see RQ8
      datin_ff <= 1'b0;
      rx_byte_ff <= `I2CME_RST_BYTE;
    end else begin
      if (rd_i & sel_rx) begin
        datin_ff <= 1'b0; // see RQ15
      end
      case (st_ff)
        ST_IDLE: begin
          ph_ff <= 2'h0;
          if (go_any) begin
            ackin_ff <= 1'b0; // see RQ6
            cmplt_ff <= 1'b0; // see RQ7
            bit_cnt_ff <= `I2CME_BIT_FIRST;
            op_start_ff <= go_start;
            op_rd_ff <= go_data & dir_rd_ff;
          end
          if (go_start) begin
            shift_ff <= wdata_i[7:0];
            dir_rd_ff <= wdata_i[`I2CME_TX_DIR]; // see RQ10
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            st_ff <= ST_START;
          end else if (go_stop) begin
            st_ff <= ST_STOP;
          end else if (go_data) begin
            // Read data ignores the written value
            shift_ff <= wdata_i[7:0]; // see RQ11
            sda_oe_ff <= dir_rd_ff ? 1'b0 : ~wdata_i[`I2CME_TX_MSB]; // see RQ12
            st_ff <= ST_BIT;
          end
        end
        ST_START: begin
          if (tick) begin
            if (ph_ff == 2'h0) begin
              sda_oe_ff <= 1'b1;
              ph_ff <= 2'h1;
            end else begin
              scl_oe_ff <= 1'b1;
              sda_oe_ff <= ~shift_ff[`I2CME_TX_MSB]; // see RQ9
              ph_ff <= 2'h0;
              st_ff <= ST_BIT;
            end
          end
        end
        ST_BIT: begin
          if (tick) begin
            if (ph_ff == 2'h0) begin
              scl_oe_ff <= 1'b0;
              ph_ff <= 2'h1;
            end else begin
              scl_oe_ff <= 1'b1;
              shift_ff <= {shift_ff[6:0], sda_sync_ff};
              ph_ff <= 2'h0;
              if (bit_cnt_ff == `I2CME_BIT_LAST) begin
                sda_oe_ff <= op_rd_ff & control_ff[`I2CME_CTL_ACKOUT]; // see RQ20
                st_ff <= ST_ACK;
              end else begin
                bit_cnt_ff <= bit_cnt_ff - 3'h1;
                sda_oe_ff <= op_rd_ff ? 1'b0 : ~shift_ff[6]; // see RQ11
              end
            end
          end
        end
        ST_ACK: begin
          if (tick) begin
            if (ph_ff == 2'h0) begin
              scl_oe_ff <= 1'b0;
              ph_ff <= 2'h1;
            end else begin
              scl_oe_ff <= 1'b1;
              sda_oe_ff <= 1'b0;
              ph_ff <= 2'h0;
              if (op_rd_ff) begin
                rx_byte_ff <= shift_ff; // see RQ12
                datin_ff <= 1'b1;
              end else begin
                ackin_ff <= ~sda_sync_ff; // see RQ5
              end
              cmplt_ff <= 1'b1; // see RQ7 see RQ16
              st_ff <= ST_IDLE;
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            if (ph_ff == 2'h0) begin
              sda_oe_ff <= 1'b1;
              ph_ff <= 2'h1;
            end else if (ph_ff == 2'h1) begin
              scl_oe_ff <= 1'b0;
              ph_ff <= 2'h2;
            end else begin
              sda_oe_ff <= 1'b0; // see RQ13
              cmplt_ff <= 1'b1; // see RQ17
              ph_ff <= 2'h0;
              st_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          st_ff <= ST_IDLE;
          ph_ff <= 2'h0;
        end
      endcase
    end
  end

  // ********************************
  // Read data
  // ********************************
  always @* begin
    nxt_rdata = 32'h00000000;
    if (sel_prescale) begin
      nxt_rdata[15:0] = prescale_ff;
    end else if (sel_control) begin
      nxt_rdata[3:0] = control_ff;
    end else if (sel_status) begin
      nxt_rdata[`I2CME_STS_ERR] = err_ff; // see RQ21
      nxt_rdata[`I2CME_STS_ACKIN] = ackin_ff;
      nxt_rdata[`I2CME_STS_CMPLT] = cmplt_ff;
      nxt_rdata[`I2CME_STS_DATIN] = datin_ff;
    end else if (sel_tx) begin
      nxt_rdata[7:0] = tx_byte_ff; // see RQ21
    end else if (sel_rx) begin
      nxt_rdata[7:0] = rx_byte_ff;
    end
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= 32'h00000000;
      pin_lo_ff <= 1'b0;
    end else begin
      // Data stands only in the cycle after the strobe
      rdata_ff <= rd_i ? nxt_rdata : 32'h00000000;
      pin_lo_ff <= 1'b0;
    end
  end

  assign rdata_o = rdata_ff;
  assign scl_o = pin_lo_ff;
  assign sda_o = pin_lo_ff;
  assign scl_oe_o = scl_oe_ff;
  assign sda_oe_o = sda_oe_ff;

endmodule

// ### i2cme_checker.sv
// Port assertions for the two-wire master
`timescale 1ns/1ps
`include "i2cme_consts.vh"
module i2cme_checker (
  // Clock and reset
  input wire core_clk_i,
  input wire rstn_i,
  // Register port
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  // Pin enables
  input wire scl_oe_o,
  input wire sda_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire wc = wr_i && addr_i == `I2CME_ADDR_CONTROL;
  wire rc = rd_i && addr_i == `I2CME_ADDR_CONTROL;
  wire rs = rd_i && addr_i == `I2CME_ADDR_STATUS;
  reg err_ff;
  reg en_ff;
  reg [15:0] pre_ff;
  reg [15:0] lo_ff;
  reg [15:0] hi_ff;
  // Enable tracking is pessimistic: a locked write still counts
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_ff <= 1'b0;
      en_ff <= 1'b0;
      pre_ff <= `I2CME_RST_PRESCALE;
      lo_ff <= 16'h0;
      hi_ff <= 16'h0;
    end else begin
      err_ff <= rs ? 1'b0 : ((wc && (&wdata_i[3:2])) ? 1'b1 : err_ff);
      en_ff <= en_ff | (wc & wdata_i[0]);
      if (wr_i && addr_i == `I2CME_ADDR_PRESCALE) pre_ff <= wdata_i[15:0];
      lo_ff <= scl_oe_o ? lo_ff + 16'h1 : 16'h0;
      hi_ff <= scl_oe_o ? 16'h0 : hi_ff + 16'h1;
    end
  end
  property p_rdata_idle;
    !rd_i |=> rdata_o == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_upper_zero;
    rd_i |=> rdata_o[31:16] == 16'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_err_flag;
    rs |=> rdata_o[`I2CME_STS_ERR] == $past(err_ff);
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag wrong");
  property p_ctl_locked;
    rc && err_ff |=> rdata_o[3:0] == 4'h0;
  endproperty
  a_ctl_locked: assert property (p_ctl_locked) else $error("control not cleared");
  property p_no_bus_off;
    !en_ff |-> !scl_oe_o && !sda_oe_o;
  endproperty
  a_no_bus_off: assert property (p_no_bus_off) else $error("bus driven while off");
  property p_start_byte;
    $rose(sda_oe_o) && !scl_oe_o |-> ##[1:1000] $rose(scl_oe_o);
  endproperty
  a_start_byte: assert property (p_start_byte) else $error("no clock after start");
  property p_scl_low;
    $fell(scl_oe_o) |-> {1'b0, lo_ff} >= {1'b0, pre_ff} + 17'h1;
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low too short");
  property p_scl_high;
    $rose(scl_oe_o) |-> {1'b0, hi_ff} >= {1'b0, pre_ff} + 17'h1;
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  c_conflict: cover property (wc && (&wdata_i[3:2]));
  c_start: cover property ($rose(sda_oe_o) && !scl_oe_o);
  c_rx_read: cover property (rd_i && addr_i == `I2CME_ADDR_RX_BYTE);
endmodule

// ### i2cme_slave_model.sv
// Behavioural two-wire slave facing the master
`timescale 1ns/1ps
module i2cme_slave_model #(
  parameter [7:0] RD_BYTE = 8'ha5
) (
  // Bus wires
  input wire scl_i,
  input wire sda_i,
  // Test control
  input wire nack_i,
  // Drive and capture
  output reg sda_oe_o = 1'b0,
  output reg [7:0] last_byte_o = 8'h0
);
  reg act_ff = 1'b0;
  reg first_ff = 1'b0;
  reg rd_ff = 1'b0;
  reg [3:0] cnt_ff = 4'h0;
  reg [7:0] sh_ff = 8'h0;
  // Delay guards against data moving with the clock fall
  always @(negedge sda_i) begin
    #1;
    if (scl_i) begin
      act_ff = 1'b1;
      first_ff = 1'b1;
      cnt_ff = 4'h0;
    end
  end
  always @(posedge sda_i) begin
    #1;
    if (scl_i) act_ff = 1'b0;
  end
  always @(posedge scl_i) begin
    if (act_ff && cnt_ff == 4'h8) begin
      cnt_ff = 4'h0;
      last_byte_o = sh_ff;
      if (first_ff) rd_ff = sh_ff[0];
      else if (rd_ff && sda_i) act_ff = 1'b0;
      first_ff = 1'b0;
    end else if (act_ff) begin
      sh_ff = {sh_ff[6:0], sda_i};
      cnt_ff = cnt_ff + 4'h1;
    end
  end
  always @(negedge scl_i) begin
    if (!act_ff) sda_oe_o = 1'b0;
    else if (cnt_ff == 4'h8) sda_oe_o = (first_ff || !rd_ff) && !nack_i;
    else sda_oe_o = rd_ff && !first_ff && !RD_BYTE[3'h7 - cnt_ff[2:0]];
  end
endmodule

// ### tb.sv
// Self-checking bench for the two-wire master
`timescale 1ns/1ps
`include "i2cme_consts.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
  localparam [31:0] PRE = `I2CME_ADDR_PRESCALE;
  localparam [31:0] CTL = `I2CME_ADDR_CONTROL;
  localparam [31:0] STS = `I2CME_ADDR_STATUS;
  localparam [31:0] TXB = `I2CME_ADDR_TX_BYTE;
  localparam [31:0] RXB = `I2CME_ADDR_RX_BYTE;
  localparam [31:0] UNM = 32'hfef800b8;
  typedef struct packed {logic [31:0] wa; logic [31:0] wd; logic [31:0] ra; logic [31:0] ex;} i2cme_row_t;
  i2cme_row_t rows [0:9];
  reg core_clk_i = 1'b0;
  reg rstn_i = 1'b0;
  reg [31:0] addr_i = 32'h0;
  reg [31:0] wdata_i = 32'h0;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg slave_nack = 1'b0;
  reg [31:0] rv;
  wire [31:0] rdata_o;
  wire scl_oe_o;
  wire sda_oe_o;
  wire s_oe;
  wire [7:0] s_byte;
  wire scl_lo;
  wire sda_lo;
  wire scl = !scl_oe_o;
  wire sda = !(sda_oe_o || s_oe);
  integer n_fail = 0;
  integer check_count = 0;
  integer i;
  always #2.5 core_clk_i = !core_clk_i;
  i2cme_core u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl), .scl_o(scl_lo), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_lo),
    .sda_oe_o(sda_oe_o));
  i2cme_slave_model u_slv (.scl_i(scl), .sda_i(sda), .nack_i(slave_nack), .sda_oe_o(s_oe), .last_byte_o(s_byte));
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    begin
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [31:0] a);
    begin
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 rv = rdata_o;
    end
  endtask
  // Launch one operation, then poll with a bounded count
  task op(input [31:0] ctl, input [31:0] tx, input [31:0] sts);
    integer k;
    begin
      wr(CTL, ctl);
      wr(TXB, tx);
      rd(STS);
      `CHK("complete cleared", 1'b0, rv[1])
      for (k = 0; k < 300 && rv[1] !== 1'b1; k = k + 1) rd(STS);
      if (rv[1] !== 1'b1) begin
        n_fail++;
        $display("[FAIL] completion wait expected 1 seen %b", rv[1]);
        give_verdict;
      end
      `CHK("status after op", sts, rv)
    end
  endtask
  task stop_bus;
    begin
      op(32'h5, 32'h0, 32'h2);
      rd(CTL);
      `CHK("stop self clear", 32'h1, rv)
      `CHK("bus idle", 2'b11, {scl, sda})
      `CHK("pin drive level", 2'b00, {scl_lo, sda_lo})
    end
  endtask
  initial begin
    rows = '{'{UNM, 32'h0, PRE, 32'h1f3}, '{UNM, 32'h0, CTL, 32'h0}, '{UNM, 32'h0, STS, 32'h2},
      '{UNM, 32'h0, TXB, 32'h0}, '{UNM, 32'h0, RXB, 32'h0}, '{PRE, 32'hffff1234, PRE, 32'h1234},
      '{CTL, 32'hfffffff2, CTL, 32'h2}, '{TXB, 32'h1ff, TXB, 32'hff}, '{RXB, 32'hff, RXB, 32'h0},
      '{STS, 32'hf, STS, 32'h2}};
    repeat (12) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    for (i = 0; i < 10; i = i + 1) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra);
      `CHK("row read", rows[i].ex, rv)
    end
    wr(CTL, 32'hd);
    rd(CTL);
    `CHK("control cleared", 32'h0, rv)
    wr(CTL, 32'h1);
    rd(CTL);
    `CHK("control locked", 32'h0, rv)
    rd(STS);
    `CHK("error set", 32'ha, rv)
    rd(STS);
    `CHK("error cleared", 32'h2, rv)
    wr(CTL, 32'h1);
    rd(CTL);
    `CHK("control open", 32'h1, rv)
    wr(PRE, 32'h1);
    op(32'h9, 32'ha0, 32'h6);
    rd(CTL);
    `CHK("start self clear", 32'h1, rv)
    `CHK("address byte", 8'ha0, s_byte)
    op(32'h1, 32'h3c, 32'h6);
    `CHK("data byte", 8'h3c, s_byte)
    slave_nack <= 1'b1;
    op(32'h1, 32'h55, 32'h2);
    slave_nack <= 1'b0;
    `CHK("nack byte", 8'h55, s_byte)
    stop_bus;
    op(32'h9, 32'ha1, 32'h6);
    op(32'h3, 32'h0, 32'h3);
    wr(TXB, 32'h0);
    rd(STS);
    `CHK("refused fetch", 32'h3, rv)
    rd(RXB);
    `CHK("rx byte", 32'ha5, rv)
    rd(STS);
    `CHK("data flag", 32'h2, rv)
    op(32'h1, 32'h0, 32'h3);
    rd(RXB);
    `CHK("rx last", 32'ha5, rv)
    stop_bus;
    give_verdict;
  end
endmodule
bind i2cme_core i2cme_checker u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o));
